// ### design/hbspi_top.sv
// H-bridge pin control, serial slave, write queue and half-bridge sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "hbspi_defines.svh"

// ****************************************************************
// Write queue
// ****************************************************************
module hbspi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } hbspi_fifo_st_t;
  hbspi_fifo_st_t st_q, st_d;
  logic push, pop;

  // Full and empty come straight from the fill count.
  assign o_in_ready = (st_q.cnt != (AW + 1)'(DEPTH));
  assign o_out_valid = (st_q.cnt != '0);
  assign o_out_data = st_q.mem[st_q.rd];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Pointer and count update.
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = i_in_data;
      st_d.wr = AW'(st_q.wr + 1'b1);
    end
    if (pop) begin
      st_d.rd = AW'(st_q.rd + 1'b1);
    end
    st_d.cnt = (AW + 1)'(st_q.cnt + push - pop);
  end

  // State register.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ****************************************************************
// Half-bridge sequencer
// ****************************************************************
module hbspi_half #(
  parameter int DEAD_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire hbspi_pkg::hbspi_tgt_t i_target,
  input wire logic [DEAD_W-1:0] i_dead_cyc,
  output hbspi_pkg::hbspi_half_t o_drive
);
  typedef struct packed {
    hbspi_pkg::hbspi_phase_t phase;
    hbspi_pkg::hbspi_tgt_t cur;
    logic [DEAD_W-1:0] cnt;
    hbspi_pkg::hbspi_half_t drv;
  } hbspi_half_st_t;
  hbspi_half_st_t st_q, st_d;

  // Turning off is immediate; turning a switch on waits out the gap.
  always_comb begin
    st_d = st_q;
    if (i_target == hbspi_pkg::TGT_OFF) begin
      st_d.phase = hbspi_pkg::PH_STEADY;
      st_d.cur = hbspi_pkg::TGT_OFF;
      st_d.drv = '0;
    end else if (i_target != st_q.cur) begin
      st_d.phase = hbspi_pkg::PH_DEAD;
      st_d.cur = i_target;
      st_d.cnt = i_dead_cyc;
      st_d.drv = '0;
    end else if (st_q.phase == hbspi_pkg::PH_DEAD) begin
      if (st_q.cnt == '0) begin
        st_d.phase = hbspi_pkg::PH_STEADY;
        st_d.drv.hs = (st_q.cur == hbspi_pkg::TGT_HIGH);
        st_d.drv.ls = (st_q.cur == hbspi_pkg::TGT_LOW);
      end else begin
        st_d.cnt = DEAD_W'(st_q.cnt - 1'b1);
      end
    end
  end

  // State register.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '{phase: hbspi_pkg::PH_STEADY, cur: hbspi_pkg::TGT_OFF,
                cnt: '0, drv: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_drive = st_q.drv;

  // Both switches of one leg never conduct together.
  a_no_shoot_thru: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !(st_q.drv.hs && st_q.drv.ls))
    else $error("High and low side on together.");
  // A switch turns on only after the leg was fully off the cycle before.
  a_gap_before_on: assert property (@(posedge i_core_clk) disable iff (i_srst)
    ($rose(st_q.drv.ls) || $rose(st_q.drv.hs)) |->
      ($past(st_q.drv) == '0))
    else $error("Switch turned on without an off gap.");
endmodule

// ****************************************************************
// Serial link, clocked by the master's serial clock
// ****************************************************************
module hbspi_link (
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  input wire logic [15:0] i_snap,
  output logic o_miso,
  output logic [15:0] o_rx_word,
  output logic [3:0] o_rx_bits,
  output logic o_rx_full
);
  typedef struct packed {
    logic [4:0] tcnt;
    logic miso;
  } hbspi_tx_st_t;
  typedef struct packed {
    logic [15:0] word;
    logic [3:0] bits;
    logic full;
  } hbspi_rx_st_t;
  hbspi_tx_st_t tx_q, tx_d;
  hbspi_rx_st_t rx_q, rx_d;
  logic first;

  // Output side: the reply word MSB first, then the input echoed back.
  always_comb begin
    tx_d = tx_q;
    if (tx_q.tcnt < `HBSPI_TX_LAST) begin
      tx_d.miso = i_snap[~tx_q.tcnt[3:0]];
      tx_d.tcnt = 5'(tx_q.tcnt + 1'b1);
    end else begin
      tx_d.miso = rx_q.word[15];
    end
  end

  // Output changes on rising edges; chip select high ends the frame.
  always_ff @(posedge i_spi_sclk or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  // Input side: the first falling edge of a frame restarts the count.
  assign first = (tx_q.tcnt == 5'h01);
  always_comb begin
    rx_d.word = {rx_q.word[14:0], i_spi_mosi};
    rx_d.bits = first ? 4'h1 : 4'(rx_q.bits + 1'b1);
    rx_d.full = first ? 1'b0 : (rx_q.full || (rx_q.bits == 4'hf));
  end

  // Input sampled on falling edges while selected only.
  always_ff @(negedge i_spi_sclk) begin
    if (!i_spi_cs_n) begin
      rx_q <= rx_d;
    end
  end

  // Before the first rising edge the reply MSB is already shown.
  assign o_miso = (tx_q.tcnt == 5'h00) ? i_snap[15] : tx_q.miso;
  assign o_rx_word = rx_q.word;
  assign o_rx_bits = rx_q.bits;
  assign o_rx_full = rx_q.full;

  // Once the reply is out, each bit is the one received 16 bits before.
  a_echo_input: assert property (@(posedge i_spi_sclk) disable iff (i_spi_cs_n)
    ($past(tx_q.tcnt) == `HBSPI_TX_LAST) &&
      (tx_q.tcnt == `HBSPI_TX_LAST) |->
      (tx_q.miso == $past(rx_q.word[15])))
    else $error("Echoed bit does not match input.");
  // Reply bits leave MSB first.
  a_msb_first: assert property (@(posedge i_spi_sclk) disable iff (i_spi_cs_n)
    ($past(tx_q.tcnt) < `HBSPI_TX_LAST) && ($past(tx_q.tcnt) != 5'h00) &&
      (tx_q.tcnt != 5'h00) |->
      (tx_q.miso == i_snap[~$past(tx_q.tcnt[3:0])]))
    else $error("Reply bit out of order.");
endmodule

module hbspi_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int DEAD_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_wake_input,
  input wire logic i_tristate_input,
  input wire logic i_leg_one_control,
  input wire logic i_leg_two_control,
  input wire logic [`HBSPI_FAULT_W-1:0] i_fault_status,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_miso,
  output logic o_miso_oe_n,
  output hbspi_pkg::hbspi_drive_t o_drive,
  output logic o_sleep,
  output logic o_standby,
  output logic [2:0] o_slew_sel,
  output logic o_fault_flag_n,
  output logic o_fault_flag_oe_n
);
  localparam int SW = `HBSPI_FAULT_W + 5;
  localparam int DEAD_CYC = (`HBSPI_DEAD_NS * `HBSPI_CORE_MHZ + 999) / 1000;

  typedef struct packed {
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic cs_prev;
    logic [1:0] prev_addr;
    logic [15:0] snap;
    logic [7:0] mask;
    logic [2:0] slew;
    logic pend;
    logic [15:0] pend_word;
    logic sleep;
    logic standby;
    logic flag_oe_n;
  } hbspi_core_st_t;
  hbspi_core_st_t st_q, st_d;

  logic wake_s, tris_s, leg1_s, leg2_s, cs_s;
  logic [`HBSPI_FAULT_W-1:0] flt_s;
  logic [15:0] rx_word;
  logic [3:0] rx_bits;
  logic rx_full;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [15:0] fifo_out_data;
  hbspi_pkg::hbspi_word_t wr_word, rx_cmd;
  hbspi_pkg::hbspi_tgt_t tgt_one, tgt_two;
  logic [DEAD_W-1:0] dead_cyc;
  logic [7:0] rd_data;

  // ****************************************************************
  // Pin synchronisers and decode
  // ****************************************************************
  // Second synchroniser stage fans out to the logic.
  assign {wake_s, tris_s, leg1_s, leg2_s, cs_s, flt_s} = st_q.sync2;
  assign rx_cmd = rx_word;
  assign wr_word = fifo_out_data;

  // Writes wait in the queue while asleep, so the queue really fills.
  assign fifo_out_ready = wake_s;

  // Gap length grows with the slew setting.
  assign dead_cyc = DEAD_W'(DEAD_CYC * (int'(st_q.slew) + 1));

  // Bridge targets from the wake, tristate and leg inputs.
  always_comb begin
    tgt_one = hbspi_pkg::TGT_OFF;
    tgt_two = hbspi_pkg::TGT_OFF;
    if (wake_s && !tris_s) begin
      tgt_one = leg1_s ? hbspi_pkg::TGT_HIGH : hbspi_pkg::TGT_LOW;
      tgt_two = leg2_s ? hbspi_pkg::TGT_HIGH : hbspi_pkg::TGT_LOW;
    end
  end

  // Read data of the register addressed by the last committed frame.
  always_comb begin
    unique case (st_q.prev_addr)
      `HBSPI_ADDR_FAULT: rd_data = flt_s;
      `HBSPI_ADDR_MASK: rd_data = st_q.mask;
      `HBSPI_ADDR_CONFIG: rd_data = {5'h00, st_q.slew};
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************************************
  // Core state
  // ****************************************************************
  // Sync, frame commit, register apply, status and fault flag.
  always_comb begin
    st_d = st_q;
    st_d.sync1 = {i_wake_input, i_tristate_input, i_leg_one_control,
                  i_leg_two_control, i_spi_cs_n, i_fault_status};
    st_d.sync2 = st_q.sync1;
    st_d.cs_prev = cs_s;
    // Reply word is frozen while selected and refreshed while idle.
    if (cs_s) begin
      st_d.snap = {1'b0, st_q.prev_addr, 5'h00, rd_data};
    end
    // A whole word on select rising is queued and its address remembered.
    // A frame that ends while an earlier commit still waits is dropped.
    if (cs_s && !st_q.cs_prev && rx_full && (rx_bits == 4'h0) &&
        !st_q.pend) begin
      st_d.pend = 1'b1;
      st_d.pend_word = rx_word;
      st_d.prev_addr = rx_cmd.addr;
    end else if (st_q.pend && fifo_in_ready) begin
      st_d.pend = 1'b0;
    end
    // Queued writes take effect as they leave the queue.
    if (fifo_out_valid && fifo_out_ready && wr_word.write) begin
      if (wr_word.addr == `HBSPI_ADDR_MASK) begin
        st_d.mask = wr_word.data;
      end else if (wr_word.addr == `HBSPI_ADDR_CONFIG) begin
        st_d.slew = wr_word.data[2:0];
      end
    end
    st_d.sleep = !wake_s;
    st_d.standby = wake_s && tris_s;
    st_d.flag_oe_n = !(|(flt_s & st_q.mask));
  end

  // State register.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '{sync1: '0, sync2: '0, cs_prev: 1'b1, prev_addr: '0,
                snap: '0, mask: `HBSPI_MASK_RST, slew: `HBSPI_SLEW_RST,
                pend: 1'b0, pend_word: '0, sleep: 1'b1, standby: 1'b0,
                flag_oe_n: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Submodules
  // ****************************************************************
  hbspi_fifo #(.WIDTH(`HBSPI_WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_in_valid(st_q.pend),
    .o_in_ready(fifo_in_ready),
    .i_in_data(st_q.pend_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  hbspi_link u_link (
    .i_spi_sclk(i_spi_sclk),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_mosi(i_spi_mosi),
    .i_snap(st_q.snap),
    .o_miso(o_miso),
    .o_rx_word(rx_word),
    .o_rx_bits(rx_bits),
    .o_rx_full(rx_full)
  );

  hbspi_half #(.DEAD_W(DEAD_W)) u_half_one (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_target(tgt_one),
    .i_dead_cyc(dead_cyc),
    .o_drive(o_drive.one)
  );

  hbspi_half #(.DEAD_W(DEAD_W)) u_half_two (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_target(tgt_two),
    .i_dead_cyc(dead_cyc),
    .o_drive(o_drive.two)
  );

  // Serial output is driven only while selected.
  assign o_miso_oe_n = i_spi_cs_n;
  assign o_sleep = st_q.sleep;
  assign o_standby = st_q.standby;
  assign o_slew_sel = st_q.slew;
  assign o_fault_flag_n = 1'b0;
  assign o_fault_flag_oe_n = st_q.flag_oe_n;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sleep_all_off: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !wake_s |=> (o_drive == '0) && o_sleep)
    else $error("Switches on while asleep.");
  a_standby_all_off: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    (wake_s && tris_s) |=> (o_drive == '0) && o_standby && !o_sleep)
    else $error("Switches on in standby.");
  a_route_forward: assert property (@(posedge i_core_clk)
    disable iff (i_srst)
    (wake_s && !tris_s && leg1_s && !leg2_s)[*8] |->
      ##[0:300] (o_drive.one.hs && o_drive.two.ls))
    else $error("Forward drive not reached.");
  a_fault_flag: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (|(flt_s & st_q.mask)) |=> !o_fault_flag_oe_n)
    else $error("Fault flag not pulled low.");
  a_flag_release: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !(|(flt_s & st_q.mask)) |=> o_fault_flag_oe_n)
    else $error("Fault flag low without fault.");
  a_miso_hiz: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (cs_s && i_spi_cs_n) |-> o_miso_oe_n)
    else $error("Serial output driven while idle.");
  a_commit_queue: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (cs_s && !st_q.cs_prev && rx_full && (rx_bits == 4'h0) &&
     !st_q.pend) |=>
      st_q.pend && (st_q.prev_addr == $past(rx_cmd.addr)))
    else $error("Completed frame not committed.");
  a_slew_write: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (fifo_out_valid && fifo_out_ready && wr_word.write &&
     (wr_word.addr == `HBSPI_ADDR_CONFIG)) |=>
      (o_slew_sel == $past(wr_word.data[2:0])))
    else $error("Slew setting not applied.");
endmodule
`default_nettype wire

// ### design/hbspi_defines.svh
// Constants for the H-bridge pin control and serial slave block.
`ifndef HBSPI_DEFINES_SVH
`define HBSPI_DEFINES_SVH
`define HBSPI_CORE_MHZ 50
`define HBSPI_DEAD_NS 100
`define HBSPI_WORD_BITS 16
`define HBSPI_ADDR_FAULT 2'h0
`define HBSPI_ADDR_MASK 2'h1
`define HBSPI_ADDR_CONFIG 2'h2
`define HBSPI_MASK_RST 8'hff
`define HBSPI_SLEW_RST 3'h3
`define HBSPI_FAULT_W 8
`define HBSPI_TX_LAST 5'h10
`endif

// ### design/hbspi_pkg.sv
// Types shared by the H-bridge pin control and serial slave block.
package hbspi_pkg;
  // One half-bridge: high-side and low-side switch enables.
  typedef struct packed {
    logic hs;
    logic ls;
  } hbspi_half_t;
  // Both half-bridges of the full bridge.
  typedef struct packed {
    hbspi_half_t one;
    hbspi_half_t two;
  } hbspi_drive_t;
  // Wanted level of one bridge output.
  typedef enum logic [1:0] {TGT_OFF, TGT_HIGH, TGT_LOW} hbspi_tgt_t;
  // Phase of a half-bridge sequencer.
  typedef enum logic [1:0] {PH_STEADY, PH_DEAD} hbspi_phase_t;
  // Serial word as it is committed.
  typedef struct packed {
    logic write;
    logic [1:0] addr;
    logic [4:0] pad;
    logic [7:0] data;
  } hbspi_word_t;
endpackage

// ### tb/hbspi_master.sv
// Serial master model that frames words for the slave under test.
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Serial master
// ****************************************************************
module hbspi_master (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  // Clock rests low and select high outside frames.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One frame of n bits at a 30 ns clock; the reply is shifted into got.
  // The 90 ns lead lets the reply snapshot settle before the first edge.
  task automatic xfer(input logic [31:0] word, input int nbits,
                      output logic [31:0] got);
    got = 32'h0;
    #5;
    o_cs_n = 1'b0;
    #90;
    for (int i = nbits - 1; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_mosi = word[i];
      #15;
      got = {got[30:0], i_miso};
      o_sclk = 1'b0;
      #15;
    end
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released data shows no stale bit.
    #120;
  endtask
endmodule
`default_nettype wire

// ### tb/hbspi_top_test.sv
// Self-checking bench for the H-bridge pin control and serial slave.
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Bench top
// ****************************************************************
module hbspi_top_test;
  localparam logic [15:0] LEG_TAB = 16'ha965;
  logic i_core_clk, i_srst, wake, tris, leg1, leg2;
  logic sclk, cs_n, mosi, miso, miso_oe_n, flag_n, flag_oe_n;
  logic sleep, standby;
  logic [7:0] faults;
  logic [2:0] slew;
  logic [31:0] got;
  wire logic miso_w;
  wire logic flag_w;
  hbspi_pkg::hbspi_drive_t drive;
  int bad_count, n_compared, g3, g0;

  // Wire levels: data undriven when released, flag pulled up.
  assign miso_w = miso_oe_n ? 1'bz : miso;
  assign flag_w = flag_oe_n ? 1'b1 : flag_n;

  hbspi_top #(.FIFO_DEPTH(16), .DEAD_W(8)) DUT (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_wake_input(wake),
    .i_tristate_input(tris), .i_leg_one_control(leg1),
    .i_leg_two_control(leg2), .i_fault_status(faults),
    .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
    .o_miso(miso), .o_miso_oe_n(miso_oe_n), .o_drive(drive),
    .o_sleep(sleep), .o_standby(standby), .o_slew_sel(slew),
    .o_fault_flag_n(flag_n), .o_fault_flag_oe_n(flag_oe_n)
  );
  hbspi_master PM (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .i_miso(miso_w));

  // Core clock of 20 ns.
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  task automatic end_sim;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Legs never short a half-bridge; data enable follows select.
  always @(negedge i_core_clk) begin
    if (!i_srst) begin
      chk("shoot", 32'h0, 32'({drive.one.hs & drive.one.ls,
        drive.two.hs & drive.two.ls}));
      chk("miso oe", 32'(cs_n), 32'(miso_oe_n));
    end
  end

  task automatic t_reset;
    chk("drive", 32'h0, 32'(drive));
    chk("sleep", 32'h1, 32'(sleep));
    chk("slew", 32'h3, 32'(slew));
    chk("flag", 32'h1, 32'(flag_w));
  endtask

  task automatic t_legs;
    @(posedge i_core_clk);
    wake <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge i_core_clk);
      {leg1, leg2} <= 2'(i);
      cyc(60);
      chk("legs", 32'(LEG_TAB[4*i +: 4]), 32'(drive));
    end
  endtask

  task automatic t_tristate;
    @(posedge i_core_clk);
    tris <= 1'b1;
    cyc(6);
    chk("tri drive", 32'h0, 32'(drive));
    chk("standby", 32'h1, 32'(standby));
    chk("tri sleep", 32'h0, 32'(sleep));
    @(posedge i_core_clk);
    tris <= 1'b0;
    cyc(60);
    chk("tri off", 32'ha, 32'(drive));
  endtask

  task automatic t_sleep;
    @(posedge i_core_clk);
    wake <= 1'b0;
    cyc(6);
    chk("sleep drive", 32'h0, 32'(drive));
    chk("sleep", 32'h1, 32'(sleep));
    @(posedge i_core_clk);
    wake <= 1'b1;
    cyc(60);
    chk("awake", 32'h0, 32'(sleep));
    chk("awake drive", 32'ha, 32'(drive));
  endtask

  // Reversal must pass through all-off; the gap length is returned.
  task automatic t_gap(output int gap);
    gap = 0;
    @(posedge i_core_clk);
    {leg1, leg2} <= 2'b10;
    cyc(60);
    @(posedge i_core_clk);
    {leg1, leg2} <= 2'b01;
    for (int i = 0; i < 10 && drive !== 4'h0; i++) @(negedge i_core_clk);
    while (drive === 4'h0 && gap < 300) begin
      gap++;
      @(negedge i_core_clk);
    end
    chk("reverse", 32'h6, 32'(drive));
  endtask

  // Mask write, reply of the previous address and echo in a chain.
  task automatic t_spi;
    @(posedge i_core_clk);
    faults <= 8'h35;
    cyc(6);
    chk("flag set", 32'h0, 32'(flag_w));
    PM.xfer(32'ha00f, 16, got);
    chk("reply", 32'h0035, got);
    cyc(10);
    @(posedge i_core_clk);
    faults <= 8'h30;
    cyc(6);
    chk("flag masked", 32'h1, 32'(flag_w));
    PM.xfer(32'h5a3c2000, 32, got);
    chk("echo", 32'h200f5a3c, got);
    cyc(10);
    chk("slew kept", 32'h3, 32'(slew));
    PM.xfer(32'hc000, 16, got);
    cyc(10);
    chk("slew new", 32'h0, 32'(slew));
  endtask

  task automatic t_refused;
    PM.xfer(32'h00c005, 24, got);
    chk("reply slew", 32'h400000, got);
    cyc(10);
    chk("not taken", 32'h0, 32'(slew));
  endtask

  // Fill the write queue while asleep; the overflow frame is dropped.
  task automatic t_fill;
    @(posedge i_core_clk);
    wake <= 1'b0;
    cyc(6);
    for (int i = 0; i < 18; i++) begin
      PM.xfer(i == 17 ? 32'hc007 : 32'hc002, 16, got);
      cyc(1);
    end
    chk("asleep", 32'h0, 32'(slew));
    @(posedge i_core_clk);
    wake <= 1'b1;
    cyc(60);
    chk("drained", 32'h2, 32'(slew));
  endtask

  // Main sequence.
  initial begin
    i_srst = 1'b1;
    {wake, tris, leg1, leg2} = 4'h0;
    faults = 8'h00;
    repeat (20) @(posedge i_core_clk);
    i_srst <= 1'b0;
    cyc(4);
    t_reset();
    t_legs();
    t_tristate();
    t_sleep();
    t_gap(g3);
    t_spi();
    t_gap(g0);
    chk("gap", 32'd15, 32'(g3 - g0));
    t_refused();
    t_fill();
    end_sim();
  end

  // Watchdog against a hang.
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
